// >>> verilog/i2c_target_byte_access.v
`include "i2c_target_consts.vh"

module i2c_target_byte_access
(
    // clock and reset
    input wire ref_clk_i,
    input wire arst_n_i,
    // serial bus pins
    input wire scl_i,
    input wire sda_i,
    output wire sda_o,
    output wire sda_oe_n_o,
    // configured control code
    input wire [3:0] ctrl_code_i,
    // user preload port into the memory space
    input wire usr_we_i,
    input wire [10:0] usr_addr_i,
    input wire [7:0] usr_data_i,
    // committed write and pointer view
    output wire wr_stb_o,
    output wire [10:0] wr_addr_o,
    output wire [7:0] wr_data_o,
    output wire [10:0] ptr_o
);

    localparam integer HOLD_CYC = `I2CT_HOLD_CYC;
    localparam [2:0] HOLD_LOAD = HOLD_CYC[2:0];

    wire [1:0] pins_s;
    wire scl_s;
    wire sda_s;
    wire scl_rise;
    wire scl_fall;
    wire start_det;
    wire stop_det;
    wire [7:0] mem_rd;

    reg scl_q_ff;
    reg sda_q_ff;
    reg [2:0] state_ff;
    reg [1:0] kind_ff;
    reg [3:0] bit_cnt_ff;
    reg [7:0] shift_ff;
    reg [10:0] ptr_ff;
    reg [2:0] blk_ff;
    reg rw_ff;
    reg drive_ff;
    reg pend_ff;
    reg [2:0] hold_cnt_ff;
    reg wr_stb_ff;
    reg [10:0] wr_addr_ff;
    reg [7:0] wr_data_ff;
    reg [7:0] mem_ff [0:`I2CT_MEM_DEPTH-1];

    // next pointer value, wrapping in the 11-bit space
    function [10:0] ptr_inc;
        input [10:0] p;
        begin
            ptr_inc = p + 11'h001;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisation and bus event detection
    i2ct_sync u_sync
    (
        .ref_clk_i(ref_clk_i),
        .arst_n_i(arst_n_i),
        .async_i({scl_i, sda_i}),
        .sync_o(pins_s)
    );

    assign scl_s = pins_s[1];
    assign sda_s = pins_s[0];
    assign scl_rise = scl_s & ~scl_q_ff;
    assign scl_fall = ~scl_s & scl_q_ff;
    // data moving while the clock stays high marks start or stop
    assign start_det = scl_s & scl_q_ff & sda_q_ff & ~sda_s;
    assign stop_det = scl_s & scl_q_ff & ~sda_q_ff & sda_s;

    ////////////////////////////////////////////////////////////////////////////
    // memory space
    assign mem_rd = mem_ff[ptr_ff];

    // committed bus writes win over the user preload port
    always @(posedge ref_clk_i)
    begin
        if (wr_stb_ff)
        begin
            mem_ff[wr_addr_ff] <= wr_data_ff;
        end
        else if (usr_we_i)
        begin
            mem_ff[usr_addr_i] <= usr_data_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // byte sequencer
    always @(posedge ref_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            scl_q_ff <= 1'b1;
            sda_q_ff <= 1'b1;
            state_ff <= `I2CT_ST_IDLE;
            kind_ff <= `I2CT_K_CTRL;
            bit_cnt_ff <= 4'h0;
            shift_ff <= 8'h00;
            ptr_ff <= 11'h000;
            blk_ff <= 3'h0;
            rw_ff <= 1'b0;
            drive_ff <= 1'b0;
            pend_ff <= 1'b0;
            hold_cnt_ff <= 3'h0;
            wr_stb_ff <= 1'b0;
            wr_addr_ff <= 11'h000;
            wr_data_ff <= 8'h00;
        end
        else
        begin
            scl_q_ff <= scl_s;
            sda_q_ff <= sda_s;
            wr_stb_ff <= 1'b0;
            // apply a scheduled data-line change after the output hold time
            if (hold_cnt_ff != 3'h0)
            begin
                hold_cnt_ff <= hold_cnt_ff - 3'h1;
                if (hold_cnt_ff == 3'h1)
                begin
                    drive_ff <= pend_ff;
                end
            end
            if (start_det)
            begin
                // a repeated start drops any write in progress, pointer untouched
                state_ff <= `I2CT_ST_RX;
                kind_ff <= `I2CT_K_CTRL;
                bit_cnt_ff <= 4'h0;
                drive_ff <= 1'b0;
                hold_cnt_ff <= 3'h0;
            end
            else if (stop_det)
            begin
                state_ff <= `I2CT_ST_IDLE;
                drive_ff <= 1'b0;
                hold_cnt_ff <= 3'h0;
            end
            else
            begin
                case (state_ff)
                    `I2CT_ST_IDLE:
                    begin
                        bit_cnt_ff <= 4'h0;
                    end
                    `I2CT_ST_RX:
                    begin
                        if (scl_rise && bit_cnt_ff != `I2CT_BYTE_BITS)
                        begin
                            shift_ff <= {shift_ff[6:0], sda_s};
                            bit_cnt_ff <= bit_cnt_ff + 4'h1;
                        end
                        else if (scl_fall && bit_cnt_ff == `I2CT_BYTE_BITS)
                        begin
                            bit_cnt_ff <= 4'h0;
                            case (kind_ff)
                                `I2CT_K_CTRL:
                                begin
                                    if (shift_ff[`I2CT_CODE_HI:`I2CT_CODE_LO] == ctrl_code_i)
                                    begin
                                        rw_ff <= shift_ff[`I2CT_RW_BIT];
                                        if (!shift_ff[`I2CT_RW_BIT])
                                        begin
                                            blk_ff <= shift_ff[`I2CT_BLK_HI:`I2CT_BLK_LO];
                                        end
                                        state_ff <= `I2CT_ST_ACK;
                                        pend_ff <= 1'b1;
                                        hold_cnt_ff <= HOLD_LOAD;
                                    end
                                    else
                                    begin
                                        state_ff <= `I2CT_ST_IDLE;
                                    end
                                end
                                `I2CT_K_WADDR:
                                begin
                                    ptr_ff <= {blk_ff, shift_ff};
                                    state_ff <= `I2CT_ST_ACK;
                                    pend_ff <= 1'b1;
                                    hold_cnt_ff <= HOLD_LOAD;
                                end
                                default:
                                begin
                                    // commit alongside the acknowledge
                                    wr_stb_ff <= 1'b1;
                                    wr_addr_ff <= ptr_ff;
                                    wr_data_ff <= shift_ff;
                                    ptr_ff <= ptr_inc(ptr_ff);
                                    state_ff <= `I2CT_ST_ACK;
                                    pend_ff <= 1'b1;
                                    hold_cnt_ff <= HOLD_LOAD;
                                end
                            endcase
                        end
                    end
                    `I2CT_ST_ACK:
                    begin
                        if (scl_fall)
                        begin
                            if (kind_ff == `I2CT_K_CTRL && rw_ff)
                            begin
                                // read: present pointer byte goes out msb first
                                state_ff <= `I2CT_ST_TX;
                                shift_ff <= mem_rd;
                                ptr_ff <= ptr_inc(ptr_ff);
                                pend_ff <= ~mem_rd[7];
                                hold_cnt_ff <= HOLD_LOAD;
                                bit_cnt_ff <= 4'h1;
                            end
                            else
                            begin
                                state_ff <= `I2CT_ST_RX;
                                pend_ff <= 1'b0;
                                hold_cnt_ff <= HOLD_LOAD;
                                bit_cnt_ff <= 4'h0;
                                if (kind_ff == `I2CT_K_CTRL)
                                begin
                                    kind_ff <= `I2CT_K_WADDR;
                                end
                                else
                                begin
                                    kind_ff <= `I2CT_K_WDATA;
                                end
                            end
                        end
                    end
                    `I2CT_ST_TX:
                    begin
                        if (scl_fall)
                        begin
                            hold_cnt_ff <= HOLD_LOAD;
                            if (bit_cnt_ff == `I2CT_BYTE_BITS)
                            begin
                                pend_ff <= 1'b0; // release for master acknowledge
                                state_ff <= `I2CT_ST_RACK;
                            end
                            else
                            begin
                                shift_ff <= {shift_ff[6:0], 1'b0};
                                pend_ff <= ~shift_ff[6];
                                bit_cnt_ff <= bit_cnt_ff + 4'h1;
                            end
                        end
                    end
                    `I2CT_ST_RACK:
                    begin
                        if (scl_rise)
                        begin
                            if (sda_s)
                            begin
                                state_ff <= `I2CT_ST_IDLE;
                            end
                            else
                            begin
                                // acknowledged: next fall loads the following byte
                                state_ff <= `I2CT_ST_ACK;
                            end
                        end
                    end
                    default:
                    begin
                        state_ff <= `I2CT_ST_IDLE;
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs
    assign sda_o = 1'b0; // open drain: only ever pulls low
    assign sda_oe_n_o = ~drive_ff;
    assign wr_stb_o = wr_stb_ff;
    assign wr_addr_o = wr_addr_ff;
    assign wr_data_o = wr_data_ff;
    assign ptr_o = ptr_ff;

endmodule

// >>> pkg/i2c_target_consts.vh
`ifndef I2C_TARGET_CONSTS_VH
`define I2C_TARGET_CONSTS_VH

////////////////////////////////////////////////////////////////////////////////
// address space and byte layout
`define I2CT_ADDR_W 11
`define I2CT_MEM_DEPTH 2048
`define I2CT_BYTE_BITS 4'h8
`define I2CT_CODE_HI 7
`define I2CT_CODE_LO 4
`define I2CT_BLK_HI 3
`define I2CT_BLK_LO 1
`define I2CT_RW_BIT 0

// bus address that the control code and block bits normally form
`define I2CT_CHIP_ADDR 7'h08

////////////////////////////////////////////////////////////////////////////////
// sequencer states
`define I2CT_ST_IDLE 3'h0
`define I2CT_ST_RX 3'h1
`define I2CT_ST_ACK 3'h2
`define I2CT_ST_TX 3'h3
`define I2CT_ST_RACK 3'h4

// meaning of the byte being received
`define I2CT_K_CTRL 2'h0
`define I2CT_K_WADDR 2'h1
`define I2CT_K_WDATA 2'h2

////////////////////////////////////////////////////////////////////////////////
// timing
`define I2CT_CLK_PERIOD_NS 10
`define I2CT_T_DH_NS 50
`define I2CT_HOLD_CYC ((`I2CT_T_DH_NS + `I2CT_CLK_PERIOD_NS - 1) / `I2CT_CLK_PERIOD_NS)
`define I2CT_SCL_MAX_KHZ 400

`endif

// >>> verilog/i2ct_sync.v
// two-stage synchroniser for the serial clock and data pins
module i2ct_sync
(
    // clock and reset
    input wire ref_clk_i,
    input wire arst_n_i,
    // raw pins and synchronised levels
    input wire [1:0] async_i,
    output wire [1:0] sync_o
);

    reg [1:0] meta_ff;
    reg [1:0] sync_ff;

    // idle bus level is high on both lines
    always @(posedge ref_clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            meta_ff <= 2'h3;
            sync_ff <= 2'h3;
        end
        else
        begin
            meta_ff <= async_i;
            sync_ff <= meta_ff;
        end
    end

    assign sync_o = sync_ff;

endmodule

// >>> testbench/i2c_target_byte_access_props.sv
module i2c_target_byte_access_props
(
    // clock and reset
    input wire ref_clk_i,
    input wire arst_n_i,
    // serial bus pins
    input wire scl_i,
    input wire sda_i,
    input wire sda_o,
    input wire sda_oe_n_o,
    // configuration and preload
    input wire [3:0] ctrl_code_i,
    input wire usr_we_i,
    input wire [10:0] usr_addr_i,
    input wire [7:0] usr_data_i,
    // commit and pointer view
    input wire wr_stb_o,
    input wire [10:0] wr_addr_o,
    input wire [7:0] wr_data_o,
    input wire [10:0] ptr_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!arst_n_i);
    ////////////////////////////////////////////////////////////////////////////
    // line released, no commit, pointer cleared after reset
    property p_rst; $rose(arst_n_i) |-> sda_oe_n_o && !wr_stb_o && ptr_o == 11'h0; endproperty
    a_rst: assert property (p_rst) else $error("state after reset wrong");
    property p_pulse; wr_stb_o |=> !wr_stb_o; endproperty
    a_pulse: assert property (p_pulse) else $error("commit strobe too long");
    property p_step; wr_stb_o |=> ptr_o == wr_addr_o + 11'h1; endproperty
    a_step: assert property (p_step) else $error("pointer not past commit");
    // acknowledge goes out five cycles after the commit
    property p_ack; wr_stb_o |-> sda_oe_n_o [*5] ##1 !sda_oe_n_o; endproperty
    a_ack: assert property (p_ack) else $error("data ack not at commit");
    property p_hold; !wr_stb_o |-> $stable(wr_addr_o) && $stable(wr_data_o); endproperty
    a_hold: assert property (p_hold) else $error("commit view moved");
    property p_od; sda_o == 1'b0; endproperty
    a_od: assert property (p_od) else $error("data pin driven high");
    // target only starts pulling while the clock is low, and holds a while
    property p_low; $fell(sda_oe_n_o) |-> !scl_i; endproperty
    a_low: assert property (p_low) else $error("drive began with clock high");
    property p_len; $fell(sda_oe_n_o) |-> !sda_oe_n_o [*8]; endproperty
    a_len: assert property (p_len) else $error("drive too short");
    c_commit: cover property (wr_stb_o);
    c_drive: cover property ($fell(sda_oe_n_o));
    c_wrap: cover property (wr_stb_o && wr_addr_o == 11'h7ff);
endmodule

bind i2c_target_byte_access i2c_target_byte_access_props u_props
(
    .ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .scl_i(scl_i), .sda_i(sda_i),
    .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o), .ctrl_code_i(ctrl_code_i),
    .usr_we_i(usr_we_i), .usr_addr_i(usr_addr_i), .usr_data_i(usr_data_i),
    .wr_stb_o(wr_stb_o), .wr_addr_o(wr_addr_o), .wr_data_o(wr_data_o), .ptr_o(ptr_o)
);

// >>> testbench/i2c_master_model.sv
module i2c_master_model
(
    // bench clock
    input wire clk_i,
    // bus wires
    input wire sda_i,
    output logic scl_o,
    output logic sda_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // clock stands high and data released between frames
    initial
    begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end
    task automatic w(input int n);
        repeat (n) @(negedge clk_i);
    endtask
    // one bit: long low phase covers the target's output delay
    task automatic bit_x(input logic b, output logic r);
        w(2);
        sda_o = b;
        w(10);
        scl_o = 1'b1;
        w(4);
        r = sda_i;
        w(4);
        scl_o = 1'b0;
    endtask
    // start or repeated start
    task automatic start;
        w(2);
        sda_o = 1'b1;
        w(10);
        scl_o = 1'b1;
        w(8);
        sda_o = 1'b0;
        w(8);
        scl_o = 1'b0;
    endtask
    // stop closes every frame
    task automatic stop;
        w(2);
        sda_o = 1'b0;
        w(10);
        scl_o = 1'b1;
        w(8);
        sda_o = 1'b1;
        w(8);
    endtask
    // byte msb first, then the ninth bit
    task automatic xbyte(input logic [7:0] d, input logic ai, output logic [7:0] r,
                         output logic ao);
        for (int i = 7; i >= 0; i--)
            bit_x(d[i], r[i]);
        bit_x(ai, ao);
    endtask
endmodule

// >>> testbench/i2c_target_byte_access_tb.sv
module i2c_target_byte_access_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic usr_we_i = 1'b0;
    logic [10:0] usr_addr_i = 11'h0;
    logic [7:0] usr_data_i = 8'h0;
    logic [3:0] ctrl_code_i = 4'h1;
    wire mst_scl, mst_sda, sda, sda_o, sda_oe_n_o, wr_stb_o;
    wire [10:0] wr_addr_o, ptr_o;
    wire [7:0] wr_data_o;
    int fails = 0;
    int n_tests = 0;
    logic [18:0] expq [$];
    logic [7:0] mem [0:2047];
    logic [7:0] rd;
    logic [10:0] a;
    logic nak;
    // pulled-up wire: low if either side pulls
    assign sda = mst_sda & (sda_oe_n_o | sda_o);
    always #5 ref_clk_i = ~ref_clk_i;
    i2c_master_model u_mst (.clk_i(ref_clk_i), .sda_i(sda), .scl_o(mst_scl), .sda_o(mst_sda));
    i2c_target_byte_access u_dut
    (
        .ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .scl_i(mst_scl), .sda_i(sda),
        .sda_o(sda_o), .sda_oe_n_o(sda_oe_n_o), .ctrl_code_i(ctrl_code_i),
        .usr_we_i(usr_we_i), .usr_addr_i(usr_addr_i), .usr_data_i(usr_data_i),
        .wr_stb_o(wr_stb_o), .wr_addr_o(wr_addr_o), .wr_data_o(wr_data_o), .ptr_o(ptr_o)
    );
    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [18:0] seen, input logic [18:0] exp, input string m);
        n_tests++;
        if (seen !== exp)
        begin
            fails++;
            $display("BAD %0t %s", $time, m);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // write-direction control byte, then word address when accepted
    task automatic hdr(input logic [3:0] c, input logic [10:0] ad);
        u_mst.start();
        u_mst.xbyte({c, ad[10:8], 1'b0}, 1'b1, rd, nak);
        check(nak, c !== ctrl_code_i, "control ack");
        if (c === ctrl_code_i)
        begin
            u_mst.xbyte(ad[7:0], 1'b1, rd, nak);
            check(nak, 1'b0, "word address ack");
        end
    endtask
    // byte write; the commit must land before the stop
    task automatic wrb(input logic [10:0] ad, input logic [7:0] d);
        hdr(ctrl_code_i, ad);
        expq.push_back({ad, d});
        u_mst.xbyte(d, 1'b1, rd, nak);
        check(nak, 1'b0, "data ack");
        check(expq.size(), 0, "commit at ack");
        u_mst.stop();
        mem[ad] = d;
        check(ptr_o, 11'(ad + 11'h1), "pointer after write");
    endtask
    // read-direction control byte, one byte out, nack and stop
    task automatic rdb(input logic [10:0] ad);
        u_mst.start();
        u_mst.xbyte({ctrl_code_i, ad[10:8], 1'b1}, 1'b1, rd, nak);
        check(nak, 1'b0, "read control ack");
        u_mst.xbyte(8'hff, 1'b1, rd, nak);
        u_mst.stop();
        check(rd, mem[ad], "read data");
    endtask
    // each commit is matched against the oldest noted write
    always @(negedge ref_clk_i)
        if (wr_stb_o === 1'b1)
        begin
            if (expq.size() == 0)
                check(1'b1, 1'b0, "stray commit");
            else
                check({wr_addr_o, wr_data_o}, expq.pop_front(), "commit");
        end
    // hang guard
    initial
    begin
        repeat (100000) @(posedge ref_clk_i);
        check(1'b1, 1'b0, "timeout");
        tally_and_finish();
    end
    initial
    begin
        void'($urandom(32'h422542a8));
        repeat (16) @(negedge ref_clk_i);
        arst_n_i = 1'b1;
        repeat (4) @(negedge ref_clk_i);
        check(ptr_o, 11'h0, "reset pointer");
        usr_we_i = 1'b1;
        for (int i = 0; i < 2048; i++)
        begin
            usr_addr_i = i[10:0];
            usr_data_i = 8'($urandom);
            mem[i] = usr_data_i;
            @(negedge ref_clk_i);
        end
        usr_we_i = 1'b0;
        $display("test preload done");
        // edges of the space first, then random places
        for (int k = 0; k < 6; k++)
        begin
            a = (k < 2) ? {11{k[0]}} : 11'($urandom);
            wrb(a, 8'($urandom));
            hdr(ctrl_code_i, a);
            rdb(a);
            rdb(a + 11'h1);
            check(ptr_o, 11'(a + 11'h2), "pointer after reads");
        end
        $display("test write and read done");
        // every control code: only the configured one is answered
        // a fresh configured code shows that the port, not a constant, is matched
        ctrl_code_i = 4'($urandom);
        for (int c = 0; c < 16; c++)
        begin
            hdr(c[3:0], 11'h2a5);
            u_mst.stop();
        end
        $display("test refusal done");
        tally_and_finish();
    end
endmodule
